// file: rtl/frbt_pkg.sv
// package: constants and types of the flash rewrite bus timing block
package frbt_pkg;
   // register byte offsets
   localparam logic [7:0]  ADDR_CLK_CTL  = 8'h00;
   localparam logic [7:0]  ADDR_CFG_PROG = 8'h04;
   localparam logic [7:0]  ADDR_CFG_DATA = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
   // reset values and writable masks
   localparam logic [31:0] CLK_CTL_RST   = 32'h0000_0000;
   localparam logic [31:0] CFG_RST       = 32'h0000_0000;
   localparam logic [31:0] CLK_CTL_MASK  = 32'h0000_001f;
   localparam logic [31:0] CFG_MASK      = 32'h0000_0f7f;
   // clock control fields
   localparam int          BASE_SEL_LSB  = 0;
   localparam int          PDIV_LSB      = 2;
   localparam int          MEM_EXP_BIT   = 4;
   // bus config fields
   localparam int          MULT_LSB      = 0;
   localparam int          RD_CODE_LSB   = 2;
   localparam int          RD_EXTRA_BIT  = 6;
   localparam int          WR_SETUP_LSB  = 8;
   localparam int          WR_WIDTH_LSB  = 10;
   // status fields
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_STROBE_BIT = 1;
   localparam int          ST_WRITE_BIT  = 2;
   localparam int          ST_LAST_LSB   = 8;
   // field encodings
   localparam logic [1:0]  MULT_X4       = 2'h3;
   localparam logic [1:0]  PDIV_2        = 2'h0;
   localparam logic [1:0]  PDIV_3        = 2'h1;
   localparam logic [1:0]  PDIV_4        = 2'h2;
   localparam logic [6:0]  MULT_F3       = 7'h03;
   localparam logic [6:0]  MULT_F4       = 7'h04;
   // read strobe shortening and write hold, half base cycles; slowest read step
   localparam logic [6:0]  RD_DELTA_D2   = 7'h02;
   localparam logic [6:0]  RD_DELTA_D3   = 7'h03;
   localparam logic [6:0]  RD_DELTA_D4   = 7'h04;
   localparam logic [6:0]  WR_HOLD_H     = 7'h02;
   localparam logic [2:0]  STEP_SLOWEST  = 3'h6;
   // read wait codes for steps 1 to 7
   localparam logic [3:0]  RD_CODE_LIST [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'ha, 4'hb, 4'hf};
   // read cycle in base cycles, steps 1 to 7
   localparam logic [5:0]  RD_D2_M3_X0 [7] = '{6'h04, 6'h08, 6'h0a, 6'h0e, 6'h10, 6'h14, 6'h16};
   localparam logic [5:0]  RD_D2_M3_X1 [7] = '{6'h06, 6'h08, 6'h0c, 6'h0e, 6'h12, 6'h14, 6'h18};
   localparam logic [5:0]  RD_D2_M4    [7] = '{6'h06, 6'h0a, 6'h0e, 6'h12, 6'h16, 6'h1a, 6'h1e};
   localparam logic [5:0]  RD_D3_M3    [7] = '{6'h06, 6'h09, 6'h0c, 6'h0f, 6'h12, 6'h15, 6'h18};
   localparam logic [5:0]  RD_D3_M4_X0 [7] = '{6'h06, 6'h09, 6'h0f, 6'h12, 6'h15, 6'h1b, 6'h1e};
   localparam logic [5:0]  RD_D3_M4_X1 [7] = '{6'h06, 6'h0c, 6'h0f, 6'h12, 6'h18, 6'h1b, 6'h1e};
   localparam logic [5:0]  RD_D4_M3_X0 [7] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h10, 6'h14, 6'h18};
   localparam logic [5:0]  RD_D4_M3_X1 [7] = '{6'h08, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h14, 6'h18};
   localparam logic [5:0]  RD_D4_M4    [7] = '{6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20};
   // bus responses
   localparam logic [1:0]  AXI_OKAY      = 2'h0;
   localparam logic [1:0]  AXI_SLVERR    = 2'h2;
   // sequencer states, gray along the write cycle; reads go from strobe straight to idle
   typedef enum logic [1:0] {
      FRBT_IDLE   = 2'h0,
      FRBT_SETUP  = 2'h1,
      FRBT_STROBE = 2'h3,
      FRBT_HOLD   = 2'h2
   } frbt_state_t;
endpackage

// file: rtl/frbt_tick_gen.sv
// half base clock tick generator
`timescale 1ns/1ps
module frbt_tick_gen #(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // divide select
   input  wire logic [1:0] div_sel,
   // tick out
   output logic            tick
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] mask;

   assign mask = ~({W{1'b1}} << div_sel);
   assign tick = ((cnt_q & mask) == mask);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule

// file: rtl/frbt_timing_calc.sv
// phase lengths of one rewrite bus cycle from its settings
`timescale 1ns/1ps
module frbt_timing_calc (
   // settings
   input  wire logic [31:0] cfg,
   input  wire logic [1:0]  pdiv,
   input  wire logic        is_write,
   // phase lengths in half base cycles and the read wait step
   output logic [6:0]       pre_h,
   output logic [6:0]       str_h,
   output logic [6:0]       hold_h,
   output logic [2:0]       step
);
   logic       m4;
   logic       extra;
   logic [3:0] code;
   logic [5:0] tc;
   logic [6:0] delta;
   logic [6:0] mfac;
   logic [6:0] su;
   logic [6:0] ww;
   logic [6:0] tmp;

   assign m4    = (cfg[frbt_pkg::MULT_LSB +: 2] == frbt_pkg::MULT_X4);
   assign extra = cfg[frbt_pkg::RD_EXTRA_BIT];
   assign code  = cfg[frbt_pkg::RD_CODE_LSB +: 4];
   assign mfac  = m4 ? frbt_pkg::MULT_F4 : frbt_pkg::MULT_F3;
   assign su    = {5'h00, cfg[frbt_pkg::WR_SETUP_LSB +: 2]};
   assign ww    = {5'h00, cfg[frbt_pkg::WR_WIDTH_LSB +: 2]} + 7'h01;

   always_comb begin
      step = frbt_pkg::STEP_SLOWEST;
      for (int i = 0; i < 7; i++) begin
         if (code == frbt_pkg::RD_CODE_LIST[i]) begin
            step = 3'(i);
         end
      end
   end

   always_comb begin
      case (pdiv)
         frbt_pkg::PDIV_2: begin
            delta = frbt_pkg::RD_DELTA_D2;
            if (m4) begin
               tc = frbt_pkg::RD_D2_M4[step];
            end else begin
               tc = extra ? frbt_pkg::RD_D2_M3_X1[step] : frbt_pkg::RD_D2_M3_X0[step];
            end
         end
         frbt_pkg::PDIV_3: begin
            delta = frbt_pkg::RD_DELTA_D3;
            if (m4) begin
               tc = extra ? frbt_pkg::RD_D3_M4_X1[step] : frbt_pkg::RD_D3_M4_X0[step];
            end else begin
               tc = frbt_pkg::RD_D3_M3[step];
            end
         end
         default: begin
            delta = frbt_pkg::RD_DELTA_D4;
            if (m4) begin
               tc = frbt_pkg::RD_D4_M4[step];
            end else begin
               tc = extra ? frbt_pkg::RD_D4_M3_X1[step] : frbt_pkg::RD_D4_M3_X0[step];
            end
         end
      endcase
   end

   // write phases from setup and width steps, read phases from the read cycle and bus divide
   always_comb begin
      tmp = 7'h01 + 7'(mfac * su);
      if (is_write) begin
         pre_h  = {tmp[5:0], 1'b0};
         str_h  = 7'(mfac * ww * 7'h02);
         hold_h = frbt_pkg::WR_HOLD_H;
      end else begin
         pre_h  = delta;
         str_h  = {tc, 1'b0} - delta;
         hold_h = 7'h00;
      end
   end
endmodule

// file: rtl/frbt_top.sv
// flash rewrite bus timing sequencer with axi4-lite registers
// Contract
// - the cycle timing runs from the base clock chosen by the base divide field.
// - all phase lengths are counted in whole or half base clock cycles.
// - the read cycle comes from multiplier, wait code, extra bit and bus divide.
// - the write cycle comes from multiplier, write setup and write width; bus divide does not change it.
// - multiplier 10b is factor 3, 11b factor 4; the seven wait codes are steps 1 to 7.
// - at divide by 2 reads have strobe one cycle short of the cycle, no hold.
// - at divide by 3 reads have strobe 1.5 cycles short of the cycle, no hold.
// - at divide by 4 reads have strobe 2 cycles short of the cycle, no hold.
// - write setup codes give steps 0 to 3 and write width codes steps 1 to 4.
// - in expansion mode data cycles use the data register, else the program one.
`timescale 1ns/1ps
module frbt_top #(
   parameter int ADDR_W = 8,
   parameter int TICK_W = 3
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // rewrite cycle request
   input  wire logic              cyc_req,
   input  wire logic              cyc_write,
   input  wire logic              cyc_data_area,
   output logic                   cyc_busy,
   output logic                   cyc_done,
   // bus strobes
   output logic                   bus_rd_strobe,
   output logic                   bus_wr_strobe
);
   frbt_pkg::frbt_state_t state_q;
   logic [31:0]       clk_ctl_q;
   logic [31:0]       cfg_prog_q;
   logic [31:0]       cfg_data_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_have_q;
   logic              w_have_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              wr_en;
   logic [7:0]        waddr;
   logic [7:0]        raddr;
   logic              tick;
   logic [31:0]       cfg_sel;
   logic [6:0]        calc_pre;
   logic [6:0]        calc_str;
   logic [6:0]        calc_hold;
   logic [2:0]        calc_step;
   logic [6:0]        pre_q;
   logic [6:0]        str_q;
   logic [6:0]        hold_q;
   logic              wr_q;
   logic [1:0]        pdiv_q;
   logic [6:0]        last_len_q;
   logic [6:0]        cnt_q;
   logic [6:0]        len;
   logic              last;
   logic              start;
   logic              done_q;
   logic [31:0]       status;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction
   // axi handshakes
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign wr_en = aw_have_q && w_have_q && !bvalid_q;
   assign waddr = 8'(awaddr_q) & 8'hfc;
   assign raddr = 8'(s_axi_araddr) & 8'hfc;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_en) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_en) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // register writes and write response
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         clk_ctl_q  <= frbt_pkg::CLK_CTL_RST;
         cfg_prog_q <= frbt_pkg::CFG_RST;
         cfg_data_q <= frbt_pkg::CFG_RST;
         bvalid_q   <= 1'b0;
         bresp_q    <= frbt_pkg::AXI_OKAY;
      end else begin
         if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q  <= frbt_pkg::AXI_OKAY;
            case (waddr)
               frbt_pkg::ADDR_CLK_CTL: begin
                  clk_ctl_q <= merge(clk_ctl_q, wdata_q, wstrb_q) & frbt_pkg::CLK_CTL_MASK;
               end
               frbt_pkg::ADDR_CFG_PROG: begin
                  cfg_prog_q <= merge(cfg_prog_q, wdata_q, wstrb_q) & frbt_pkg::CFG_MASK;
               end
               frbt_pkg::ADDR_CFG_DATA: begin
                  cfg_data_q <= merge(cfg_data_q, wdata_q, wstrb_q) & frbt_pkg::CFG_MASK;
               end
               frbt_pkg::ADDR_STATUS: bresp_q <= frbt_pkg::AXI_OKAY;
               default: bresp_q <= frbt_pkg::AXI_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // status word
   always_comb begin
      status = 32'h0000_0000;
      status[frbt_pkg::ST_BUSY_BIT]        = (state_q != frbt_pkg::FRBT_IDLE);
      status[frbt_pkg::ST_STROBE_BIT]      = (state_q == frbt_pkg::FRBT_STROBE);
      status[frbt_pkg::ST_WRITE_BIT]       = wr_q;
      status[frbt_pkg::ST_LAST_LSB +: 7]   = last_len_q;
   end

   // register reads
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= frbt_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= frbt_pkg::AXI_OKAY;
         case (raddr)
            frbt_pkg::ADDR_CLK_CTL: rdata_q <= clk_ctl_q;
            frbt_pkg::ADDR_CFG_PROG: rdata_q <= cfg_prog_q;
            frbt_pkg::ADDR_CFG_DATA: rdata_q <= cfg_data_q;
            frbt_pkg::ADDR_STATUS: rdata_q <= status;
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= frbt_pkg::AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   frbt_tick_gen #(
      .W       (TICK_W)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .div_sel (clk_ctl_q[frbt_pkg::BASE_SEL_LSB +: 2]),
      .tick    (tick)
   );

   assign cfg_sel = (cyc_data_area && clk_ctl_q[frbt_pkg::MEM_EXP_BIT]) ? cfg_data_q : cfg_prog_q;
   frbt_timing_calc u_calc (
      .cfg      (cfg_sel),
      .pdiv     (clk_ctl_q[frbt_pkg::PDIV_LSB +: 2]),
      .is_write (cyc_write),
      .pre_h    (calc_pre),
      .str_h    (calc_str),
      .hold_h   (calc_hold),
      .step     (calc_step)
   );

   assign start = cyc_req && (state_q == frbt_pkg::FRBT_IDLE);
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pre_q      <= 7'h00;
         str_q      <= 7'h00;
         hold_q     <= 7'h00;
         wr_q       <= 1'b0;
         pdiv_q     <= frbt_pkg::PDIV_2;
         last_len_q <= 7'h00;
      end else if (start) begin
         pre_q      <= calc_pre;
         str_q      <= calc_str;
         hold_q     <= calc_hold;
         wr_q       <= cyc_write;
         pdiv_q     <= clk_ctl_q[frbt_pkg::PDIV_LSB +: 2];
         last_len_q <= calc_pre + calc_str + calc_hold;
      end
   end

   always_comb begin
      case (state_q)
         frbt_pkg::FRBT_SETUP: len = pre_q;
         frbt_pkg::FRBT_STROBE: len = str_q;
         frbt_pkg::FRBT_HOLD: len = hold_q;
         default: len = 7'h01;
      endcase
   end
   assign last = tick && (cnt_q == len - 7'h01);
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_q <= frbt_pkg::FRBT_IDLE;
         cnt_q   <= 7'h00;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         cnt_q  <= last ? 7'h00 : cnt_q + 7'(tick);
         case (state_q)
            frbt_pkg::FRBT_IDLE: begin
               if (start) begin
                  state_q <= frbt_pkg::FRBT_SETUP;
               end
            end
            frbt_pkg::FRBT_SETUP: begin
               if (last) begin
                  state_q <= frbt_pkg::FRBT_STROBE;
               end
            end
            frbt_pkg::FRBT_STROBE: begin
               if (last) begin
                  state_q <= (hold_q == 7'h00) ? frbt_pkg::FRBT_IDLE : frbt_pkg::FRBT_HOLD;
                  done_q  <= (hold_q == 7'h00);
               end
            end
            frbt_pkg::FRBT_HOLD: begin
               if (last) begin
                  state_q <= frbt_pkg::FRBT_IDLE;
                  done_q  <= 1'b1;
               end
            end
            default: begin
               state_q <= frbt_pkg::FRBT_IDLE;
            end
         endcase
      end
   end
   assign cyc_busy      = (state_q != frbt_pkg::FRBT_IDLE);
   assign cyc_done      = done_q;
   assign bus_rd_strobe = (state_q == frbt_pkg::FRBT_STROBE) && !wr_q;
   assign bus_wr_strobe = (state_q == frbt_pkg::FRBT_STROBE) && wr_q;
   // tick counts for checking
   logic [6:0] chk_all_q;
   logic [6:0] chk_str_q;
   logic [6:0] chk_mfac;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || start) begin
         chk_all_q <= 7'h00;
         chk_str_q <= 7'h00;
      end else if (tick && cyc_busy) begin
         chk_all_q <= chk_all_q + 7'h01;
         chk_str_q <= chk_str_q + 7'(state_q == frbt_pkg::FRBT_STROBE);
      end
   end
   assign chk_mfac = (cfg_sel[frbt_pkg::MULT_LSB +: 2] == frbt_pkg::MULT_X4) ? 7'h04 : 7'h03;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   tick_rate_a: assert property (tick && clk_ctl_q[1:0] != 2'h0 |=> !tick)
      else $error("base tick came too early");
   cycle_len_a: assert property (done_q |-> chk_all_q == last_len_q)
      else $error("cycle length not equal to setting");
   rd_hold_a: assert property ($fell(bus_rd_strobe) |-> !cyc_busy && done_q)
      else $error("read has hold after strobe");
   wr_width_a: assert property (start && cyc_write |=>
      str_q == 7'($past(chk_mfac) * 2 * ({5'h00, $past(cfg_sel[11:10])} + 7'h01)))
      else $error("write strobe width wrong");
   rd_mult4_a: assert property (start && !cyc_write && clk_ctl_q[3:2] == frbt_pkg::PDIV_2 &&
      cfg_sel[1:0] == frbt_pkg::MULT_X4 |=>
      last_len_q == 7'(8 * ($past(calc_step) + 1) + 4))
      else $error("factor 4 read cycle wrong");
   rd_div2_a: assert property (done_q && !wr_q && pdiv_q == frbt_pkg::PDIV_2 |->
      chk_str_q == last_len_q - 7'h02)
      else $error("divide 2 read strobe wrong");
   rd_div3_a: assert property (done_q && !wr_q && pdiv_q == frbt_pkg::PDIV_3 |->
      chk_str_q == last_len_q - 7'h03)
      else $error("divide 3 read strobe wrong");
   rd_div4_a: assert property (done_q && !wr_q && pdiv_q == frbt_pkg::PDIV_4 |->
      chk_str_q == last_len_q - 7'h04)
      else $error("divide 4 read strobe wrong");
   wr_setup_a: assert property (start && cyc_write |=>
      pre_q == 7'(2 * (1 + $past(chk_mfac) * $past(cfg_sel[9:8]))))
      else $error("write setup wrong");
   area_sel_a: assert property (start && !clk_ctl_q[4] |-> cfg_sel == cfg_prog_q)
      else $error("wrong area register used");
   cfg_hold_a: assert property (cyc_busy && $past(cyc_busy) |->
      $stable(pre_q) && $stable(str_q) && $stable(hold_q))
      else $error("timing changed inside a cycle");
   rd_done_c: cover property (done_q && !wr_q);
   wr_done_c: cover property (done_q && wr_q);
   data_area_c: cover property (start && cyc_data_area && clk_ctl_q[4]);
   busy_cfg_c: cover property (cyc_busy && wr_en);
endmodule

// file: dv/test_flash_rewrite_bus_timing.sv
// self-checking bench for the flash rewrite bus timing block
`timescale 1ns/1ps
module test_flash_rewrite_bus_timing;
   logic        clk_sys, rst_b;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_d;
   logic [1:0]  bresp, rresp, rsp;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        cyc_req, cyc_write, cyc_area, busy, done, rds, wrs;
   int          bad_count, checks, nb, nr, nw;
   int          cycles = 0;
   // read cycle in base cycles: rows d2 m3x0 m3x1 m4, d3 m3 m4x0 m4x1, d4 m3x0 m3x1 m4
   int          tc_tab [9][7] = '{'{4, 8, 10, 14, 16, 20, 22}, '{6, 8, 12, 14, 18, 20, 24},
      '{6, 10, 14, 18, 22, 26, 30}, '{6, 9, 12, 15, 18, 21, 24}, '{6, 9, 15, 18, 21, 27, 30},
      '{6, 12, 15, 18, 24, 27, 30}, '{4, 8, 12, 16, 16, 20, 24}, '{8, 8, 12, 16, 20, 20, 24},
      '{8, 12, 16, 20, 24, 28, 32}};
   logic [3:0]  codes [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'ha, 4'hb, 4'hf};

   frbt_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cyc_req(cyc_req),
      .cyc_write(cyc_write), .cyc_data_area(cyc_area), .cyc_busy(busy), .cyc_done(done),
      .bus_rd_strobe(rds), .bus_wr_strobe(wrs));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         tally_and_finish;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            rsp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rd_d = rdata;
            rsp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // one rewrite cycle, counting busy and strobe cycles; chg rewrites cfg, reads status mid-cycle
   task automatic cyc(input logic w, input logic area, input logic [31:0] chg);
      @(posedge clk_sys);
      cyc_req <= 1'b1;
      cyc_write <= w;
      cyc_area <= area;
      @(posedge clk_sys);
      cyc_req <= 1'b0;
      nb = 0;
      nr = 0;
      nw = 0;
      fork
         if (chg != 0) begin
            wr(frbt_pkg::ADDR_CFG_PROG, chg);
            rd(frbt_pkg::ADDR_STATUS);
         end
         begin
            #1;
            while (done !== 1'b1) begin
               if (busy === 1'b1) nb++;
               if (rds === 1'b1) nr++;
               if (wrs === 1'b1) nw++;
               @(posedge clk_sys);
               #1;
            end
         end
      join
      @(posedge clk_sys);
      #1;
      chk("done one cycle", 0, done);
   endtask

   task automatic t_regs;
      rd(frbt_pkg::ADDR_CLK_CTL);
      chk("clk_ctl reset", 32'h0, rd_d);
      wr(frbt_pkg::ADDR_CFG_PROG, 32'hffff_ffff);
      rd(frbt_pkg::ADDR_CFG_PROG);
      chk("cfg mask", frbt_pkg::CFG_MASK, rd_d);
      wr(frbt_pkg::ADDR_STATUS, 32'hffff_ffff);
      chk("ro bresp", {30'h0, frbt_pkg::AXI_OKAY}, {30'h0, rsp});
      rd(frbt_pkg::ADDR_STATUS);
      chk("status ro", 32'h0, rd_d);
      rd(8'h10);
      chk("unmapped rresp", {30'h0, frbt_pkg::AXI_SLVERR}, {30'h0, rsp});
      wr(8'h10, 32'h1);
      chk("unmapped bresp", {30'h0, frbt_pkg::AXI_SLVERR}, {30'h0, rsp});
      $display("test regs done");
   endtask

   task automatic t_read;
      int r;
      for (int pd = 0; pd < 3; pd++) begin
         wr(frbt_pkg::ADDR_CLK_CTL, pd << 2);
         for (int m = 0; m < 2; m++) for (int x = 0; x < 2; x++) for (int s = 0; s < 7; s++) begin
            r = pd * 3 + ((pd == 1) ? (m ? 1 + x : 0) : (m ? 2 : x));
            wr(frbt_pkg::ADDR_CFG_PROG, (m ? 3 : 2) | (codes[s] << 2) | (x << 6));
            cyc(1'b0, 1'b0, 32'h0);
            chk("read busy", 2 * tc_tab[r][s], nb);
            chk("read strobe", 2 * tc_tab[r][s] - 2 - pd, nr);
            chk("read wr strobe", 0, nw);
            rd(frbt_pkg::ADDR_STATUS);
            chk("status length", 2 * tc_tab[r][s], rd_d[14:8]);
         end
      end
      $display("test read table done");
   endtask

   task automatic t_write;
      int m;
      wr(frbt_pkg::ADDR_CLK_CTL, 32'h0);
      for (int mi = 2; mi < 4; mi++) for (int s = 0; s < 4; s += 3)
         for (int w = 1; w < 5; w += 3) begin
         m = mi + 1;
         wr(frbt_pkg::ADDR_CFG_PROG, mi | (s << 8) | ((w - 1) << 10));
         cyc(1'b1, 1'b0, 32'h0);
         chk("write busy", 2 * (1 + m * s) + 2 * m * w + 2, nb);
         chk("write strobe", 2 * m * w, nw);
      end
      rd(frbt_pkg::ADDR_STATUS);
      chk("status write bit", 1, rd_d[frbt_pkg::ST_WRITE_BIT]);
      $display("test write done");
   endtask

   task automatic t_area;
      wr(frbt_pkg::ADDR_CFG_PROG, 32'h02);
      wr(frbt_pkg::ADDR_CFG_DATA, 32'h3e);
      cyc(1'b0, 1'b1, 32'h0);
      chk("single chip data", 8, nb);
      wr(frbt_pkg::ADDR_CLK_CTL, 32'h10);
      cyc(1'b0, 1'b1, 32'h0);
      chk("expansion data", 44, nb);
      cyc(1'b0, 1'b0, 32'h0);
      chk("expansion program", 8, nb);
      $display("test area done");
   endtask

   task automatic t_hold;
      wr(frbt_pkg::ADDR_CLK_CTL, 32'h0);
      wr(frbt_pkg::ADDR_CFG_PROG, 32'h3f);
      cyc(1'b0, 1'b0, 32'h3);
      chk("running cycle", 60, nb);
      chk("status in strobe", 32'h3, rd_d[2:0]);
      cyc(1'b0, 1'b0, 32'h0);
      chk("next cycle", 12, nb);
      wr(frbt_pkg::ADDR_CLK_CTL, 32'h1);
      wr(frbt_pkg::ADDR_CFG_PROG, 32'h02);
      cyc(1'b0, 1'b0, 32'h0);
      chk("base div busy", 1, (nb >= 15 && nb <= 16));
      rd(frbt_pkg::ADDR_STATUS);
      chk("base div length", 8, rd_d[14:8]);
      $display("test hold and base done");
   endtask

   initial begin
      rst_b = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, cyc_req, cyc_write, cyc_area} = '0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs;
      t_read;
      t_write;
      t_area;
      t_hold;
      tally_and_finish;
   end
endmodule
